// File: core/lbtc_pkg.sv
// Package of register codes, field layout and scaling constants for the bias compensation registers
package lbtc_pkg;

  // Command codes of the registers on the management bus
  localparam logic [7:0] CMD_BIAS_SETPOINT   = 8'h15;
  localparam logic [7:0] CMD_BIAS_LINEAR     = 8'h16;
  localparam logic [7:0] CMD_BIAS_QUADRATIC  = 8'h17;

  // Field layout
  localparam int SETPOINT_W      = 10;
  localparam int SETPOINT_LSB    = 0;
  localparam int RANGE_W         = 2;
  localparam int RANGE_LSB       = 10;
  localparam int COEFF_W         = 8;
  localparam int COEFF_LSB       = 0;
  localparam int REG_W           = 16;

  // Reset values
  localparam logic [SETPOINT_W-1:0] SETPOINT_RST = 10'h000;
  localparam logic [RANGE_W-1:0]    RANGE_RST    = 2'h0;
  localparam logic [COEFF_W-1:0]    COEFF_RST    = 8'h00;
  localparam logic [REG_W-1:0]      RDATA_RST    = 16'h0000;

  // Compensation arithmetic: one unit is 2^-18
  localparam int                 TERM_W     = 26;
  localparam int                 PROD_W     = 37;
  localparam int                 FRAC_BITS  = 18;
  localparam int                 LIN_SHIFT  = 5;
  localparam logic signed [25:0] COMP_ONE   = 26'sh0040000;
  localparam logic signed [36:0] SP_MAX     = 37'sh000000003FF;
  localparam logic signed [36:0] SP_MIN     = 37'sh00000000000;

  // Nominal bias current in microamps: setpoint / 1024 * (range + 1) * 9 mA
  localparam int                 SP_SCALE_BITS = 10;
  localparam logic [13:0]        FULL_SCALE_UA = 14'h2328;
  localparam int                 UA_W          = 16;

endpackage : lbtc_pkg

// File: core/lbtc_comp_if.sv
// Interface between the register bank and the compensation datapath
`timescale 1ns/1ps
interface lbtc_comp_if;
  import lbtc_pkg::*;

  logic        [SETPOINT_W-1:0] setpoint;
  logic signed [COEFF_W-1:0]    lin_coeff;
  logic signed [COEFF_W-1:0]    quad_coeff;
  logic signed [COEFF_W-1:0]    temp_offset;
  logic                         apc_sel;
  logic        [SETPOINT_W-1:0] result;
  logic                         result_apc;

  modport bank (output setpoint, output lin_coeff, output quad_coeff, output temp_offset,
                output apc_sel, input result, input result_apc);
  modport comp (input setpoint, input lin_coeff, input quad_coeff, input temp_offset,
                input apc_sel, output result, output result_apc);
endinterface : lbtc_comp_if

// File: core/lbtc_comp.sv
// Two-stage temperature compensation of the nominal setpoint
`timescale 1ns/1ps
module lbtc_comp
  import lbtc_pkg::*;
(
  input  wire logic  clk_i,   // System clock
  input  wire logic  rst_n_i, // Synchronised reset, active low
  lbtc_comp_if.comp  cif      // Operands and result
);

  logic signed [15:0]       lin_p;
  logic signed [15:0]       sq_p;
  logic signed [23:0]       quad_p;
  logic signed [TERM_W-1:0] term_d;
  logic signed [TERM_W-1:0] term_q;
  logic        [SETPOINT_W-1:0] sp_q;
  logic                     apc_q;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] scaled;
  logic        [SETPOINT_W-1:0] result_q;
  logic                     result_apc_q;

  // Coefficients are signed two's complement bytes [RULE5]
  assign lin_p  = cif.lin_coeff * cif.temp_offset;
  assign sq_p   = cif.temp_offset * cif.temp_offset;
  assign quad_p = cif.quad_coeff * sq_p;

  // One plus linear at 2^-13 plus quadratic at 2^-18, in 2^-18 units [RULE6] [RULE7] [RULE11]
  assign term_d = COMP_ONE + (TERM_W'(lin_p) <<< LIN_SHIFT) + TERM_W'(quad_p);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_q <= COMP_ONE;
      sp_q   <= SETPOINT_RST;
      apc_q  <= 1'b0;
    end else begin
      term_q <= term_d;
      sp_q   <= cif.setpoint;
      apc_q  <= cif.apc_sel;
    end
  end

  // Setpoint taken as unsigned, zero extended [RULE1]
  assign prod   = $signed({1'b0, sp_q}) * term_q;
  assign scaled = prod >>> FRAC_BITS;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q     <= SETPOINT_RST;
      result_apc_q <= 1'b0;
    end else begin
      if (scaled < SP_MIN) begin
        result_q <= SETPOINT_RST;
      end else if (scaled > SP_MAX) begin
        result_q <= SP_MAX[SETPOINT_W-1:0];
      end else begin
        result_q <= scaled[SETPOINT_W-1:0];
      end
      result_apc_q <= apc_q;
    end
  end

  assign cif.result     = result_q;
  assign cif.result_apc = result_apc_q;

endmodule : lbtc_comp

// File: core/lbtc_regs.sv
// Bias setpoint and temperature coefficient register bank with compensated targets
`timescale 1ns/1ps
// Function
// RULE1 - Setpoint is an unsigned ten-bit integer with no sign.
// RULE2 - Setpoint and coefficients mean bias current or monitor current per loop select.
// RULE3 - Constant current: bias equals setpoint/1024 times (range+1) times 9 mA.
// RULE4 - Loop select set: setpoint is monitor diode target, scaled by monitor range.
// RULE5 - Each coefficient is a signed byte, -128 to 127, in low register byte.
// RULE6 - Constant current: linear coefficient weighs 2^-13 per degree on bias.
// RULE7 - Constant current: quadratic coefficient weighs 2^-18 per degree squared on bias.
// RULE8 - Power control: linear coefficient acts on monitor diode target.
// RULE9 - Power control: quadratic coefficient acts on monitor diode target.
// RULE10 - Full ten-bit setpoint, bits 9 to 0, applies at reference temperature.
// RULE11 - Compensated value is setpoint times (1 + c1*dT + c2*dT^2).
module lbtc_regs
  import lbtc_pkg::*;
(
  input  wire logic                    clk_i,             // System clock, 100 MHz
  input  wire logic                    rst_n_i,           // Asynchronous reset, active low
  input  wire logic [7:0]              cmd_i,             // Register command code
  input  wire logic                    wr_i,              // Write strobe
  input  wire logic [REG_W-1:0]        wdata_i,           // Write data
  input  wire logic                    rd_i,              // Read strobe
  input  wire logic                    apc_sel_i,         // Loop select: 1 power control, 0 constant current
  input  wire logic signed [7:0]       temp_offset_i,     // Temperature minus reference, degrees
  output logic [REG_W-1:0]             rdata_o,           // Read data, held until next read
  output logic                         rvalid_o,          // Read data valid pulse
  output logic [SETPOINT_W-1:0]        bias_target_o,     // Compensated bias setting
  output logic [SETPOINT_W-1:0]        monitor_target_o,  // Compensated monitor diode setting
  output logic [RANGE_W-1:0]           range_o,           // Source or monitor range select
  output logic [UA_W-1:0]              bias_nominal_ua_o, // Nominal bias current in uA
  output logic                         apc_active_o       // Power control loop active
);

  logic                    rst_meta_q;
  logic                    rst_sync_q;
  logic [SETPOINT_W-1:0]   setpoint_q;
  logic [RANGE_W-1:0]      range_q;
  logic [COEFF_W-1:0]      lin_q;
  logic [COEFF_W-1:0]      quad_q;
  logic [REG_W-1:0]        rdata_d;
  logic [REG_W-1:0]        rdata_q;
  logic                    rvalid_q;
  logic [SETPOINT_W-1:0]   bias_q;
  logic [SETPOINT_W-1:0]   mon_q;
  logic [RANGE_W-1:0]      range_out_q;
  logic [UA_W-1:0]         ua_q;
  logic                    apc_q;
  logic [11:0]             sp_range;
  logic [25:0]             ua_full;

  lbtc_comp_if cif ();

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Register writes
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      setpoint_q <= SETPOINT_RST;
      range_q    <= RANGE_RST;
      lin_q      <= COEFF_RST;
      quad_q     <= COEFF_RST;
    end else if (wr_i) begin
      case (cmd_i)
        CMD_BIAS_SETPOINT: begin
          setpoint_q <= wdata_i[SETPOINT_LSB +: SETPOINT_W]; // [RULE10]
          range_q    <= wdata_i[RANGE_LSB +: RANGE_W];
        end
        CMD_BIAS_LINEAR: begin
          lin_q <= wdata_i[COEFF_LSB +: COEFF_W]; // [RULE5]
        end
        CMD_BIAS_QUADRATIC: begin
          quad_q <= wdata_i[COEFF_LSB +: COEFF_W]; // [RULE5]
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux, reserved bits and unknown codes read zero
  always_comb begin
    rdata_d = RDATA_RST;
    case (cmd_i)
      CMD_BIAS_SETPOINT: begin
        rdata_d[SETPOINT_LSB +: SETPOINT_W] = setpoint_q;
        rdata_d[RANGE_LSB +: RANGE_W]       = range_q;
      end
      CMD_BIAS_LINEAR: begin
        rdata_d[COEFF_LSB +: COEFF_W] = lin_q;
      end
      CMD_BIAS_QUADRATIC: begin
        rdata_d[COEFF_LSB +: COEFF_W] = quad_q;
      end
      default: begin
        rdata_d = RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q  <= RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_i;
      if (rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Same coefficients serve either loop [RULE2] [RULE8] [RULE9]
  assign cif.setpoint    = setpoint_q;
  assign cif.lin_coeff   = $signed(lin_q);
  assign cif.quad_coeff  = $signed(quad_q);
  assign cif.temp_offset = temp_offset_i;
  assign cif.apc_sel     = apc_sel_i;

  lbtc_comp u_comp (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_q),
    .cif     (cif)
  );

  // Nominal current at reference temperature, unsigned setpoint [RULE1] [RULE3]
  assign sp_range = {2'h0, setpoint_q} * ({10'h000, range_q} + 12'h001);
  assign ua_full  = {14'h0000, sp_range} * {12'h000, FULL_SCALE_UA};

  // Steer compensated result to the selected loop
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bias_q      <= SETPOINT_RST;
      mon_q       <= SETPOINT_RST;
      range_out_q <= RANGE_RST;
      ua_q        <= '0;
      apc_q       <= 1'b0;
    end else begin
      apc_q       <= cif.result_apc;
      range_out_q <= range_q;
      if (cif.result_apc) begin
        mon_q  <= cif.result;          // [RULE4] [RULE8] [RULE9]
        bias_q <= SETPOINT_RST;
        ua_q   <= '0;
      end else begin
        bias_q <= cif.result;          // [RULE2] [RULE6] [RULE7]
        mon_q  <= SETPOINT_RST;
        ua_q   <= ua_full[SP_SCALE_BITS +: UA_W]; // [RULE3]
      end
    end
  end

  assign rdata_o           = rdata_q;
  assign rvalid_o          = rvalid_q;
  assign bias_target_o     = bias_q;
  assign monitor_target_o  = mon_q;
  assign range_o           = range_out_q;
  assign bias_nominal_ua_o = ua_q;
  assign apc_active_o      = apc_q;

endmodule : lbtc_regs

// File: sim/lbtc_regs_props.sv
// Checker of the bias compensation register bank ports
`timescale 1ns/1ps
module lbtc_regs_props
  import lbtc_pkg::*;
(
  input wire logic                  clk_i,             // Clock
  input wire logic                  rst_n_i,           // Reset, active low
  input wire logic [7:0]            cmd_i,             // Command code
  input wire logic                  rd_i,              // Read strobe
  input wire logic                  apc_sel_i,         // Loop select
  input wire logic [REG_W-1:0]      rdata_o,           // Read data
  input wire logic                  rvalid_o,          // Read valid
  input wire logic [SETPOINT_W-1:0] bias_target_o,     // Bias target
  input wire logic [SETPOINT_W-1:0] monitor_target_o,  // Monitor target
  input wire logic [RANGE_W-1:0]    range_o,           // Range
  input wire logic [UA_W-1:0]       bias_nominal_ua_o, // Nominal bias
  input wire logic                  apc_active_o       // Loop active
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_answer; rd_i |=> rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  property p_no_spurious; !rd_i |=> !rvalid_o; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("spurious valid");
  property p_rdata_hold; !rvalid_o |-> $stable(rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_coeff_byte;
    rvalid_o && ($past(cmd_i) == CMD_BIAS_LINEAR || $past(cmd_i) == CMD_BIAS_QUADRATIC) |-> rdata_o[15:8] == 8'h00;
  endproperty
  a_coeff_byte: assert property (p_coeff_byte) else $error("coefficient upper byte");
  property p_sp_read;
    rvalid_o && $past(cmd_i) == CMD_BIAS_SETPOINT |-> rdata_o[15:12] == 4'h0 && rdata_o[11:10] == range_o;
  endproperty
  a_sp_read: assert property (p_sp_read) else $error("setpoint read layout");
  property p_unmapped;
    rvalid_o && ($past(cmd_i) < CMD_BIAS_SETPOINT || $past(cmd_i) > CMD_BIAS_QUADRATIC) |-> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cc_mon; !apc_active_o |-> monitor_target_o == 10'h000; endproperty
  a_cc_mon: assert property (p_cc_mon) else $error("monitor target in CC");
  property p_apc_bias; apc_active_o |-> bias_target_o == 10'h000 && bias_nominal_ua_o == 16'h0000; endproperty
  a_apc_bias: assert property (p_apc_bias) else $error("bias output in APC");
  property p_align; $stable(apc_sel_i) [*8] |-> apc_active_o == apc_sel_i; endproperty
  a_align: assert property (p_align) else $error("loop select not followed");
  property p_ua_bound; bias_nominal_ua_o < ({14'h0, range_o} + 16'h1) * 16'h2328; endproperty
  a_ua_bound: assert property (p_ua_bound) else $error("nominal bias above range");
  c_read: cover property (rvalid_o && rdata_o != 16'h0000);
  c_apc: cover property (apc_active_o && monitor_target_o != 10'h000);
  c_cc: cover property (!apc_active_o && bias_target_o == 10'h3FF);
endmodule // lbtc_regs_props

bind lbtc_regs lbtc_regs_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rd_i(rd_i),
  .apc_sel_i(apc_sel_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .bias_target_o(bias_target_o),
  .monitor_target_o(monitor_target_o), .range_o(range_o), .bias_nominal_ua_o(bias_nominal_ua_o),
  .apc_active_o(apc_active_o));

// File: sim/laser_bias_temp_comp_regs_tb_top.sv
// Self-checking bench of the bias compensation register bank
`timescale 1ns/1ps
module laser_bias_temp_comp_regs_tb_top
  import lbtc_pkg::*;
;
  logic              clk, rst_n, wr, rd, apc, rvalid, apc_act;
  logic [7:0]        cmd, m_c1, m_c2;
  logic signed [7:0] dt;
  logic [15:0]       wdata, rdata, ua;
  logic [9:0]        bias_t, mon_t, m_sp;
  logic [1:0]        rng, m_rng;
  logic [31:0]       seed = 32'h58, r, r2;
  int                n_errors = 0, compares = 0;
  logic [7:0]        corner [5] = '{8'h00, 8'h7F, 8'h80, 8'h01, 8'hFF};
  lbtc_regs u_dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
    .apc_sel_i(apc), .temp_offset_i(dt), .rdata_o(rdata), .rvalid_o(rvalid), .bias_target_o(bias_t),
    .monitor_target_o(mon_t), .range_o(rng), .bias_nominal_ua_o(ua), .apc_active_o(apc_act));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] exp_tgt();
    longint v, t;
    t = longint'(dt);
    v = longint'(m_sp) * (longint'(COMP_ONE) + 32 * longint'($signed(m_c1)) * t + longint'($signed(m_c2)) * t * t);
    v = v >>> 18;
    return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
  endfunction
  function automatic logic [15:0] exp_ua();
    return 16'((int'(m_sp) * (int'(m_rng) + 1) * FULL_SCALE_UA) >> 10);
  endfunction
  function automatic logic [15:0] exp_rd(input logic [7:0] c);
    case (c)
      CMD_BIAS_SETPOINT:  return {4'h0, m_rng, m_sp};
      CMD_BIAS_LINEAR:    return {8'h00, m_c1};
      CMD_BIAS_QUADRATIC: return {8'h00, m_c2};
      default:            return 16'h0000;
    endcase
  endfunction
  task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic v, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (v !== 1'b1 || got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: read valid %b got %h expected %h", $time, v, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1 {cmd, wdata, wr} = {c, d, 1'b1};
    @(posedge clk);
    #1 wr = 1'b0;
    case (c)
      CMD_BIAS_SETPOINT:  {m_rng, m_sp} = d[11:0];
      CMD_BIAS_LINEAR:    m_c1 = d[7:0];
      CMD_BIAS_QUADRATIC: m_c2 = d[7:0];
      default:;
    endcase
  endtask
  task automatic rd_reg(input logic [7:0] c);
    @(posedge clk);
    #1 {cmd, rd} = {c, 1'b1};
    @(posedge clk);
    #1 rd = 1'b0;
    cmp_rd(rvalid, rdata, exp_rd(c));
  endtask
  task automatic chk_out(input logic a, input logic [7:0] t);
    @(posedge clk);
    #1 {apc, dt} = {a, t};
    repeat (6) @(posedge clk);
    #1 cmp_out({6'h0, bias_t}, apc ? 10'h000 : exp_tgt(), "bias");
    cmp_out({6'h0, mon_t}, apc ? exp_tgt() : 10'h000, "monitor");
    cmp_out(ua, apc ? 16'h0 : exp_ua(), "nominal");
    cmp_out({14'h0, rng}, {14'h0, m_rng}, "range");
    cmp_out({15'h0, apc_act}, {15'h0, apc}, "loop");
  endtask
  task automatic conclude();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    {rst_n, wr, rd, apc, dt, cmd, wdata} = '0;
    {m_sp, m_rng, m_c1, m_c2} = '0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    for (int c = 8'h14; c <= 8'h18; c++) rd_reg(8'(c));
    chk_out(1'b0, 8'h00);
    wr_reg(CMD_BIAS_SETPOINT, 16'hFFFF);
    wr_reg(CMD_BIAS_LINEAR, 16'hFF7F);
    wr_reg(CMD_BIAS_QUADRATIC, 16'hFF80);
    wr_reg(8'h18, 16'h1234);
    for (int c = 8'h15; c <= 8'h18; c++) rd_reg(8'(c));
    for (int i = 0; i < 10; i++) chk_out(1'(i), corner[i / 2]);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      r2 = xs();
      wr_reg(CMD_BIAS_SETPOINT + {6'h0, r[1:0]}, r[31:16]);
      wr_reg(CMD_BIAS_SETPOINT + {6'h0, r[3:2]}, r2[15:0]);
      rd_reg(CMD_BIAS_SETPOINT + {6'h0, r[5:4]});
      chk_out(r[6], r[15:8]);
    end
    // Mid-run reset clears every register and target
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    {m_sp, m_rng, m_c1, m_c2} = '0;
    repeat (3) @(posedge clk);
    for (int c = 8'h15; c <= 8'h17; c++) rd_reg(8'(c));
    chk_out(1'b0, 8'h05);
    conclude();
  end
endmodule // laser_bias_temp_comp_regs_tb_top
